// ===== rtl/ptg_defines.svh
// Behaviour
// R01: Event action off: enabling starts counting at once
// R02: Channels come out of reset in compare mode
// R03: Counter compared with every channel each tick
// R04: Buffer copied at update or force command
// R05: Match flag set on the counting tick
// R06: Match raises interrupt, event and DMA request
// R07: Mode field selects seven waveform configurations
// R08: Channel-0 period mode takes top from channel 0
// R09: Dual-slope modes update when counter reaches zero
// R10: Frequency and single-slope update on wraparound
// R11: Both-ends mode updates at top with circular buffer
// R12: Dual-slope overflow placement follows the mode
// R13: Toggle mode: output toggles on each match
// R14: Channel-0 period mode toggles output 0 on update
// R15: Single-slope up: set at top, clear at match
// R16: Single-slope down: clear at zero, set at match
// R17: Dual-slope: set rising match, clear falling match
// R18: Dual-slope works with period one and up
// R19: Prescaler divides by 1,2,4,8,16,64,256,1024
// R20: Low top: compare MSB picks the match ramp
// R21: Per-channel inversion before the pin
// R22: Count tick merges prescaler and event ticks (code: event ticks alone in count action, prescaler ticks otherwise)
// R23: Direction bit zero counts up, one down
// R24: Wrap to zero or reload top, set overflow
// R25: Valid buffer, unlocked: copy at update, clear valid
`ifndef PTG_DEFINES_SVH
`define PTG_DEFINES_SVH
// Register byte offsets
`define PTG_OFS_CTRL 8'h00
`define PTG_OFS_CMD 8'h04
`define PTG_OFS_FLAGS 8'h08
`define PTG_OFS_STATUS 8'h0C
`define PTG_OFS_INTEN 8'h10
`define PTG_OFS_EVOUT 8'h14
`define PTG_OFS_INVERT 8'h18
`define PTG_OFS_COUNT 8'h1C
`define PTG_OFS_PERIOD 8'h20
`define PTG_OFS_PERBUF 8'h24
`define PTG_OFS_CC_BASE 8'h40
`define PTG_OFS_CCB_BASE 8'h60
// Field positions
`define PTG_CTRL_EN 0
`define PTG_CTRL_DIR 1
`define PTG_CTRL_LOCK_UPDATE 2
`define PTG_CTRL_PSEL 4
`define PTG_CTRL_MODE 8
`define PTG_CTRL_EVACT 12
`define PTG_CTRL_CIRC 16
`define PTG_CTRL_CAPT 24
`define PTG_FLD_OVF 0
`define PTG_FLD_CH 8
`define PTG_ST_RUN 0
`define PTG_ST_PBV 1
`define PTG_ST_SLOPE 2
// Command codes
`define PTG_CMD_RETRIG 2'h1
`define PTG_CMD_STOP 2'h2
`define PTG_CMD_UPDATE 2'h3
// Reset value of software-visible control
`define PTG_CTRL_RST 32'h0000_0000
// Prescaler shift per select code 7..0
`define PTG_PRESC_SHIFTS {4'hA, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0}
`endif

// ===== rtl/ptg_pkg.sv
package ptg_pkg;
  // Waveform mode encoding
  typedef enum logic [2:0] {
    PTG_TOGGLE_ON_MATCH = 3'h0,
    PTG_CHANNEL0_PERIOD = 3'h1,
    PTG_SINGLE_SLOPE = 3'h2,
    PTG_DS_CRITICAL = 3'h3,
    PTG_DS_ZERO_IRQ = 3'h4,
    PTG_DS_BOTH_IRQ = 3'h5,
    PTG_DS_TOP_IRQ = 3'h6
  } ptg_wave_t;
  // Input event action
  typedef enum logic [2:0] {
    PTG_EV_OFF = 3'h0,
    PTG_EV_RETRIG = 3'h1,
    PTG_EV_START = 3'h3,
    PTG_EV_COUNT = 3'h5
  } ptg_evact_t;
  // Counter run state
  typedef enum logic [1:0] {
    PTG_IDLE = 2'b01,
    PTG_RUN = 2'b10
  } ptg_run_t;
endpackage

// ===== rtl/ptg_timer.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "ptg_defines.svh"
module ptg_timer #(
  parameter int CNT_W = 24,
  parameter int NCH = 4
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic event_i, // Input event pulse
  output logic [NCH-1:0] waveform_output_o, // Pins
  output logic [NCH-1:0] match_event_o, // Match event pulses
  output logic overflow_event_o, // Overflow event pulse
  output logic dma_req_o, // DMA request pulse
  output logic irq_o // Interrupt request level
);
  import ptg_pkg::*;

  // Elaboration check of parameters
  if (CNT_W < 2 || CNT_W > 32 || NCH < 1 || NCH > 8)
  begin : g_bad
    $error("ptg_timer: unsupported CNT_W or NCH");
  end

  typedef struct packed {
    ptg_run_t run;
    logic en;
    logic dir;
    logic lock_update;
    logic [2:0] psel;
    ptg_wave_t mode;
    ptg_evact_t evact;
    logic [NCH-1:0] circ;
    logic [NCH-1:0] capt;
    logic [9:0] pcnt;
    logic [CNT_W-1:0] cnt;
    logic slope_dn;
    logic [CNT_W-1:0] period_value;
    logic [CNT_W-1:0] perb;
    logic pbv;
    logic [NCH-1:0][CNT_W-1:0] cc;
    logic [NCH-1:0][CNT_W-1:0] ccb;
    logic [NCH-1:0] ccbv;
    logic ovf;
    logic [NCH-1:0] mflag;
    logic ovf_ie;
    logic [NCH-1:0] mie;
    logic ovf_eo;
    logic [NCH-1:0] meo;
    logic [NCH-1:0] inv;
    logic [NCH-1:0] wave;
    logic [NCH-1:0] wo;
    logic [NCH-1:0] mev;
    logic ovf_ev;
    logic dma;
    logic ack;
    logic [31:0] rdat;
  } ptg_state_t;

  ptg_state_t q, d;
  localparam logic [CNT_W-1:0] HALF = {1'b1, {(CNT_W-1){1'b0}}};

  // Byte-lane mask and zero extension
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] zx(input logic [CNT_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction

  // Bus decode, one access per ack
  logic acc, wr;
  logic [31:0] wmask;
  logic [3:0] shifts;
  logic [9:0] plast;
  assign acc = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr = acc && wb_we_i;
  assign wmask = lane_mask(wb_sel_i);

  // Prescaler end count from select code
  assign shifts = 4'(`PTG_PRESC_SHIFTS >> (4 * q.psel)); // R19
  assign plast = 10'((11'h001 << shifts) - 11'h001); // R19

  // Counting tick: prescaler, or events in count action
  logic running, presc_tick, tick;
  assign running = q.run == PTG_RUN;
  assign presc_tick = running && q.pcnt == plast;
  assign tick = (q.evact == PTG_EV_COUNT) ? (running && event_i) : presc_tick; // R22

  // Top, slope class and counter end points
  logic [CNT_W-1:0] top;
  logic dual, ds_half, at_top, at_zero, wrap, top_ev, zero_ev;
  assign top = (q.mode == PTG_CHANNEL0_PERIOD) ? q.cc[0] : q.period_value; // R08
  assign dual = q.mode inside {PTG_DS_CRITICAL, PTG_DS_ZERO_IRQ, PTG_DS_BOTH_IRQ,
                               PTG_DS_TOP_IRQ}; // R07
  assign ds_half = (q.mode inside {PTG_DS_TOP_IRQ, PTG_DS_ZERO_IRQ, PTG_DS_BOTH_IRQ})
                   && top < HALF; // R20
  assign at_top = q.cnt == top;
  assign at_zero = q.cnt == '0;
  assign wrap = tick && !dual && (q.dir ? at_zero : at_top); // R24
  assign top_ev = tick && dual && !q.slope_dn && at_top;
  assign zero_ev = tick && dual && q.slope_dn && at_zero;

  // Commands and event actions
  logic cmd_wr, retrig, force_upd, stop_cmd, start_ev;
  assign cmd_wr = wr && wb_adr_i == `PTG_OFS_CMD && wb_sel_i[0];
  assign retrig = (cmd_wr && wb_dat_i[1:0] == `PTG_CMD_RETRIG)
                  || (q.en && q.evact == PTG_EV_RETRIG && event_i);
  assign force_upd = cmd_wr && wb_dat_i[1:0] == `PTG_CMD_UPDATE; // R04
  assign stop_cmd = cmd_wr && wb_dat_i[1:0] == `PTG_CMD_STOP;
  assign start_ev = q.en && q.evact == PTG_EV_START && event_i && !running;

  // Per-channel compare and update points
  logic [NCH-1:0] match, hit, upd;
  logic upd_per;
  assign upd_per = dual ? zero_ev : (wrap || (retrig && running)); // R09 R10
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [CNT_W-1:0] cmp;
    logic ramp_ok;
    // Low top: MSB is a ramp selector, not part of the value
    assign cmp = ds_half ? {1'b0, q.cc[c][CNT_W-2:0]} : q.cc[c]; // R20
    assign ramp_ok = !ds_half || (q.cc[c][CNT_W-1] == q.slope_dn); // R20
    assign hit[c] = tick && !q.capt[c] && q.cnt == cmp; // R03 R02
    // Ramp selector gates flag, event and DMA only; the pin still sees both ramps
    assign match[c] = hit[c] && ramp_ok; // R20
    assign upd[c] = upd_per || (q.mode == PTG_DS_BOTH_IRQ && top_ev && q.circ[c]); // R11
  end

  // Next-state logic
  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] ctl;
    logic [NCH-1:0] mclr;
    logic oclr;
    wv = '0;
    ctl = '0;
    mclr = '0;
    oclr = 1'b0;
    d = q;
    d.ack = acc;
    d.mev = '0;
    d.ovf_ev = 1'b0;
    d.dma = 1'b0;
    d.pcnt = (!running || presc_tick) ? 10'h000 : q.pcnt + 10'h001; // R19

    // Counting on each tick
    if (tick && !dual)
    begin
      if (!q.dir) // R23
        d.cnt = at_top ? '0 : q.cnt + 1'b1; // R24
      else
        d.cnt = at_zero ? top : q.cnt - 1'b1; // R24
    end
    else if (tick)
    begin
      // Dual-slope turns at top and zero; top of one still alternates
      if (!q.slope_dn)
      begin
        d.cnt = at_top ? q.cnt - 1'b1 : q.cnt + 1'b1; // R17 R18
        d.slope_dn = at_top;
      end
      else
      begin
        d.cnt = at_zero ? q.cnt + 1'b1 : q.cnt - 1'b1; // R17 R18
        d.slope_dn = !at_zero;
      end
    end

    // Start, restart and stop
    if (retrig)
    begin
      d.run = PTG_RUN;
      d.cnt = (q.dir && !dual) ? top : '0;
      d.slope_dn = 1'b0;
      d.pcnt = 10'h000;
    end
    else if (start_ev)
      d.run = PTG_RUN;
    if (stop_cmd)
      d.run = PTG_IDLE;

    // Buffer to active copies
    if ((q.pbv && !q.lock_update && upd_per) || (q.pbv && force_upd))
    begin
      d.period_value = q.perb; // R25 R04
      d.pbv = 1'b0;
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (q.ccbv[c] && ((!q.lock_update && upd[c]) || force_upd))
      begin
        d.cc[c] = q.ccb[c]; // R04 R25
        d.ccbv[c] = 1'b0; // R25
      end
    end

    // Waveform generation per mode
    for (int c = 0; c < NCH; c++)
    begin
      unique case (q.mode) // R07
        PTG_TOGGLE_ON_MATCH:
          if (hit[c])
            d.wave[c] = !q.wave[c]; // R13
        PTG_CHANNEL0_PERIOD:
          if (c == 0 ? upd_per : hit[c])
            d.wave[c] = !q.wave[c]; // R14
        PTG_SINGLE_SLOPE:
          if (!q.dir)
          begin
            if (wrap)
              d.wave[c] = 1'b1; // R15
            else if (hit[c])
              d.wave[c] = 1'b0; // R15
          end
          else
          begin
            if (wrap)
              d.wave[c] = 1'b0; // R16
            else if (hit[c])
              d.wave[c] = 1'b1; // R16
          end
        PTG_DS_CRITICAL, PTG_DS_ZERO_IRQ, PTG_DS_BOTH_IRQ, PTG_DS_TOP_IRQ:
          if (hit[c])
            d.wave[c] = !q.slope_dn; // R17
        default:
          d.wave[c] = q.wave[c];
      endcase
    end

    // Bus writes; flag clears are applied before hardware sets
    if (wr)
    begin
      unique case (wb_adr_i)
        `PTG_OFS_CTRL:
        begin
          ctl = `PTG_CTRL_RST;
          ctl[`PTG_CTRL_EN] = q.en;
          ctl[`PTG_CTRL_DIR] = q.dir;
          ctl[`PTG_CTRL_LOCK_UPDATE] = q.lock_update;
          ctl[`PTG_CTRL_PSEL +: 3] = q.psel;
          ctl[`PTG_CTRL_MODE +: 3] = q.mode;
          ctl[`PTG_CTRL_EVACT +: 3] = q.evact;
          ctl[`PTG_CTRL_CIRC +: NCH] = q.circ;
          ctl[`PTG_CTRL_CAPT +: NCH] = q.capt;
          wv = (ctl & ~wmask) | (wb_dat_i & wmask);
          d.en = wv[`PTG_CTRL_EN];
          d.dir = wv[`PTG_CTRL_DIR];
          d.lock_update = wv[`PTG_CTRL_LOCK_UPDATE];
          d.psel = wv[`PTG_CTRL_PSEL +: 3];
          d.mode = ptg_wave_t'(wv[`PTG_CTRL_MODE +: 3]);
          d.evact = ptg_evact_t'(wv[`PTG_CTRL_EVACT +: 3]);
          d.circ = wv[`PTG_CTRL_CIRC +: NCH];
          d.capt = wv[`PTG_CTRL_CAPT +: NCH];
          if (!q.en && d.en && d.evact == PTG_EV_OFF)
          begin
            d.run = PTG_RUN; // R01
            d.wave = (d.mode == PTG_SINGLE_SLOPE) ? {NCH{!d.dir}} : '0; // R15 R16
          end
          if (!d.en)
            d.run = PTG_IDLE;
        end
        `PTG_OFS_FLAGS:
        begin
          wv = wb_dat_i & wmask;
          oclr = wv[`PTG_FLD_OVF];
          mclr = wv[`PTG_FLD_CH +: NCH];
        end
        `PTG_OFS_INTEN:
        begin
          if (wb_sel_i[0])
            d.ovf_ie = wb_dat_i[`PTG_FLD_OVF];
          if (wb_sel_i[1])
            d.mie = wb_dat_i[`PTG_FLD_CH +: NCH];
        end
        `PTG_OFS_EVOUT:
        begin
          if (wb_sel_i[0])
            d.ovf_eo = wb_dat_i[`PTG_FLD_OVF];
          if (wb_sel_i[1])
            d.meo = wb_dat_i[`PTG_FLD_CH +: NCH];
        end
        `PTG_OFS_INVERT:
          if (wb_sel_i[0])
            d.inv = wb_dat_i[NCH-1:0];
        `PTG_OFS_COUNT:
          d.cnt = CNT_W'((zx(q.cnt) & ~wmask) | (wb_dat_i & wmask));
        `PTG_OFS_PERIOD:
          d.period_value = CNT_W'((zx(q.period_value) & ~wmask) | (wb_dat_i & wmask));
        `PTG_OFS_PERBUF:
        begin
          d.perb = CNT_W'((zx(q.perb) & ~wmask) | (wb_dat_i & wmask));
          d.pbv = 1'b1;
        end
        default:
          ;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
        if (wb_adr_i == 8'(`PTG_OFS_CC_BASE + 4 * c))
          d.cc[c] = CNT_W'((zx(q.cc[c]) & ~wmask) | (wb_dat_i & wmask));
        if (wb_adr_i == 8'(`PTG_OFS_CCB_BASE + 4 * c))
        begin
          d.ccb[c] = CNT_W'((zx(q.ccb[c]) & ~wmask) | (wb_dat_i & wmask));
          d.ccbv[c] = 1'b1;
        end
      end
    end

    // Overflow placement per mode; hardware set beats clear
    unique case (q.mode)
      PTG_DS_TOP_IRQ:
        d.ovf_ev = top_ev; // R12
      PTG_DS_ZERO_IRQ, PTG_DS_CRITICAL:
        d.ovf_ev = zero_ev; // R12
      PTG_DS_BOTH_IRQ:
        d.ovf_ev = top_ev || zero_ev; // R12
      default:
        d.ovf_ev = wrap; // R24
    endcase
    d.ovf = (q.ovf && !oclr) || d.ovf_ev; // R24
    d.ovf_ev = d.ovf_ev && q.ovf_eo;
    d.mflag = (q.mflag & ~mclr) | match; // R05
    d.mev = match & q.meo; // R06
    d.dma = |match; // R06

    // Output inversion stage
    d.wo = d.wave ^ d.inv; // R21

    // Read mux, registered with the ack
    d.rdat = '0;
    if (acc && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `PTG_OFS_CTRL:
        begin
          d.rdat[`PTG_CTRL_EN] = q.en;
          d.rdat[`PTG_CTRL_DIR] = q.dir;
          d.rdat[`PTG_CTRL_LOCK_UPDATE] = q.lock_update;
          d.rdat[`PTG_CTRL_PSEL +: 3] = q.psel;
          d.rdat[`PTG_CTRL_MODE +: 3] = q.mode;
          d.rdat[`PTG_CTRL_EVACT +: 3] = q.evact;
          d.rdat[`PTG_CTRL_CIRC +: NCH] = q.circ;
          d.rdat[`PTG_CTRL_CAPT +: NCH] = q.capt;
        end
        `PTG_OFS_FLAGS:
        begin
          d.rdat[`PTG_FLD_OVF] = q.ovf;
          d.rdat[`PTG_FLD_CH +: NCH] = q.mflag;
        end
        `PTG_OFS_STATUS:
        begin
          d.rdat[`PTG_ST_RUN] = running;
          d.rdat[`PTG_ST_PBV] = q.pbv;
          d.rdat[`PTG_ST_SLOPE] = q.slope_dn;
          d.rdat[`PTG_FLD_CH +: NCH] = q.ccbv;
        end
        `PTG_OFS_INTEN:
        begin
          d.rdat[`PTG_FLD_OVF] = q.ovf_ie;
          d.rdat[`PTG_FLD_CH +: NCH] = q.mie;
        end
        `PTG_OFS_EVOUT:
        begin
          d.rdat[`PTG_FLD_OVF] = q.ovf_eo;
          d.rdat[`PTG_FLD_CH +: NCH] = q.meo;
        end
        `PTG_OFS_INVERT:
          d.rdat[NCH-1:0] = q.inv;
        `PTG_OFS_COUNT:
          d.rdat = zx(q.cnt);
        `PTG_OFS_PERIOD:
          d.rdat = zx(q.period_value);
        `PTG_OFS_PERBUF:
          d.rdat = zx(q.perb);
        default:
          ;
      endcase
      for (int c = 0; c < NCH; c++)
      begin
        if (wb_adr_i == 8'(`PTG_OFS_CC_BASE + 4 * c))
          d.rdat = zx(q.cc[c]);
        if (wb_adr_i == 8'(`PTG_OFS_CCB_BASE + 4 * c))
          d.rdat = zx(q.ccb[c]);
      end
    end
  end

  // State register; period resets to full count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0; // R02
      q.run <= PTG_IDLE;
      q.period_value <= '1;
    end
    else
      q <= d;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign waveform_output_o = q.wo;
  assign match_event_o = q.mev;
  assign overflow_event_o = q.ovf_ev;
  assign dma_req_o = q.dma;
  // Interrupt level from flags gated by enables
  assign irq_o = |(q.mflag & q.mie) || (q.ovf && q.ovf_ie); // R06

  // Checks
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_start_off: assert property (@(posedge clk_i) disable iff (rst_i) // R01
    wr && wb_adr_i == `PTG_OFS_CTRL && wb_sel_i[0] && wb_sel_i[1] && !q.en
    && wb_dat_i[`PTG_CTRL_EN] && wb_dat_i[`PTG_CTRL_EVACT +: 3] == 3'h0
    |=> running) else $error("enable with no event action did not start");
  a_up_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // R24
    wrap && !q.dir && !wr |=> q.cnt == '0 && q.ovf)
    else $error("up count did not wrap to zero with overflow");
  a_down_reload: assert property (@(posedge clk_i) disable iff (rst_i) // R23
    wrap && q.dir && !wr && !retrig |=> q.cnt == $past(top))
    else $error("down count did not reload top");
  a_match_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R05
    match[0] |=> q.mflag[0] ##1 (q.mflag[0] || $past(wr)))
    else $error("match flag not set or lost");
  a_match_dma: assert property (@(posedge clk_i) disable iff (rst_i) // R06
    match != '0 |=> dma_req_o ##1 (dma_req_o == $past(match != '0)))
    else $error("dma request does not follow match");
  a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    q.lock_update && !force_upd && !wr |=> q.cc[0] == $past(q.cc[0]))
    else $error("locked compare value changed");
  a_dual_turn: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    top_ev && !retrig && !wr |=> q.slope_dn ##0 q.cnt == $past(q.cnt) - 1'b1)
    else $error("dual slope did not turn at top");
  a_pwm_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    q.mode == PTG_SINGLE_SLOPE && !q.dir && match[0] && !wrap && !wr
    |=> !q.wave[0] && waveform_output_o[0] == q.inv[0])
    else $error("single slope output not cleared at match");
  c_dual_turn: cover property (@(posedge clk_i) disable iff (rst_i) top_ev ##[1:50] zero_ev);
  c_force_upd: cover property (@(posedge clk_i) disable iff (rst_i) force_upd && q.ccbv[0]);
  c_pwm_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    q.mode == PTG_SINGLE_SLOPE && wrap ##[1:50] match[0]);
endmodule

// ===== testbench/ptg_partner.sv
`timescale 1ns/1ps
// Event system stand-in: one event pulse every third clock while enabled
module ptg_partner (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic en_i, // Emit events
  output logic event_o, // Event pulse
  output logic [15:0] sent_o // Events sent so far
);
  logic [1:0] gap_q;
  // Spacing keeps every event a lone one-cycle pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_q <= 2'h0;
      event_o <= 1'b0;
      sent_o <= 16'h0000;
    end
    else
    begin
      gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
      event_o <= en_i && (gap_q == 2'h2);
      if (en_i && (gap_q == 2'h2))
        sent_o <= sent_o + 16'h0001;
    end
  end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`include "ptg_defines.svh"
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module testbench;
  import ptg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pen = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o, rdat, q;
  logic [31:0] rnd = 32'h4d42_bfeb;
  logic ack, ev, ovf, dma, irq;
  logic [3:0] wo, mev;
  logic [15:0] sent;
  int errors = 0, n_compared = 0, cycles = 0;
  int hi[4], me[4], nov, ndma;
  int sh[8] = '{0, 1, 2, 3, 4, 6, 8, 10};

  ptg_timer ptg_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .event_i(ev), .waveform_output_o(wo), .match_event_o(mev),
    .overflow_event_o(ovf), .dma_req_o(dma), .irq_o(irq));
  ptg_partner ptg_partner_inst (.clk_i(clk_i), .rst_i(rst_i), .en_i(pen), .event_o(ev),
    .sent_o(sent));

  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 22k cycles the run needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      final_report();
    end
  end

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rdat)
  endtask

  task automatic wait_ovf();
    @(posedge clk_i);
    while (ovf !== 1'b1)
      @(posedge clk_i);
  endtask

  // Tally pin high time and pulses over w cycles
  task automatic watch(input int w);
    hi = '{default: 0};
    me = '{default: 0};
    nov = 0;
    ndma = 0;
    repeat (w)
    begin
      @(posedge clk_i);
      for (int k = 0; k < 4; k++)
      begin
        hi[k] += wo[k];
        me[k] += mev[k];
      end
      nov += ovf;
      ndma += dma;
    end
  endtask

  // Settle two periods, then judge four whole periods so phase drops out
  task automatic wave(input int m, input logic dir, input int p, input logic [3:0] inv);
    int c[4];
    int period_value, q4, e;
    q4 = p / 4;
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      c[k] = 1 + k * q4 + rnd % (q4 - 1);
    end
    if (m == 1)
      c[0] = p;
    period_value = (m >= 3) ? 2 * p : p + 1;
    wr(`PTG_OFS_CTRL, 32'h0000_0000);
    wr(`PTG_OFS_PERIOD, (m == 1) ? 3 * p : p);
    wr(`PTG_OFS_INVERT, inv);
    wr(`PTG_OFS_INTEN, 32'h0000_0F01);
    wr(`PTG_OFS_EVOUT, 32'h0000_0F01);
    wr(`PTG_OFS_COUNT, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
      wr(`PTG_OFS_CC_BASE + 8'(4 * k), c[k]);
    wr(`PTG_OFS_CTRL, (m << 8) | (dir << 1) | 1);
    watch(2 * period_value);
    watch(4 * period_value);
    for (int k = 0; k < 4; k++)
    begin
      e = (m < 2) ? 2 * period_value : (m == 2) ? (dir ? 4 * c[k] : 4 * (c[k] + 1)) : 8 * (p - c[k]);
      if (inv[k])
        e = 4 * period_value - e;
      `CHK("pin high", e, hi[k])
      // Critical mode keeps full-width compare, so both ramps match
      `CHK("match events", (m == 3) ? 8 : 4, me[k])
    end
    `CHK("overflow events", (m == 5) ? 8 : 4, nov)
    `CHK("dma requests", (m == 3) ? 32 : 16, ndma)
  endtask

  // Compare buffer: held until the update point, lock honoured, force ignores lock
  task automatic bufchk(input int m);
    wr(`PTG_OFS_CTRL, 32'h0000_0000);
    wr(`PTG_OFS_COUNT, 32'h0000_0000);
    wr(`PTG_OFS_PERIOD, 32'h0000_001F);
    wr(`PTG_OFS_EVOUT, 32'h0000_0001);
    wr(`PTG_OFS_CC_BASE + 8'h04, 32'h0000_0005);
    wr(`PTG_OFS_CTRL, (m << 8) | 1);
    wait_ovf();
    wr(`PTG_OFS_CCB_BASE + 8'h04, 32'h0000_0009);
    rchk(`PTG_OFS_CC_BASE + 8'h04, 32'h0000_0005, "compare held");
    wb(1'b0, `PTG_OFS_STATUS, 32'h0000_0000);
    `CHK("buffer valid", 1'b1, rdat[9])
    wait_ovf();
    rchk(`PTG_OFS_CC_BASE + 8'h04, 32'h0000_0009, "compare updated");
    wb(1'b0, `PTG_OFS_STATUS, 32'h0000_0000);
    `CHK("buffer valid", 1'b0, rdat[9])
    wr(`PTG_OFS_CTRL, (m << 8) | 5);
    wr(`PTG_OFS_CCB_BASE + 8'h04, 32'h0000_000C);
    wait_ovf();
    wait_ovf();
    rchk(`PTG_OFS_CC_BASE + 8'h04, 32'h0000_0009, "compare locked");
    wr(`PTG_OFS_CMD, 32'h0000_0003);
    rchk(`PTG_OFS_CC_BASE + 8'h04, 32'h0000_000C, "compare forced");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("pins after reset", 4'h0, wo)
    rchk(`PTG_OFS_CTRL, 32'h0000_0000, "control reset");
    rchk(`PTG_OFS_PERIOD, 32'h00FF_FFFF, "period reset");
    wr(8'hFC, 32'hFFFF_FFFF);
    rchk(8'hFC, 32'h0000_0000, "unmapped");
    // Start-event action holds off until an event arrives
    wr(`PTG_OFS_CTRL, 32'h0000_3001);
    wb(1'b0, `PTG_OFS_STATUS, 32'h0000_0000);
    `CHK("running", 1'b0, rdat[0])
    wr(`PTG_OFS_CTRL, 32'h0000_0000);
    wr(`PTG_OFS_CTRL, 32'h0000_0001);
    wb(1'b0, `PTG_OFS_STATUS, 32'h0000_0000);
    `CHK("running", 1'b1, rdat[0])
    // Event counting: one step per event, prescaler bypassed
    wr(`PTG_OFS_CTRL, 32'h0000_0000);
    wr(`PTG_OFS_COUNT, 32'h0000_0000);
    wr(`PTG_OFS_CTRL, 32'h0000_5041);
    // Count action does not self-start; a retrigger command starts from zero
    wr(`PTG_OFS_CMD, 32'h0000_0001);
    pen <= 1'b1;
    repeat (60) @(posedge clk_i);
    pen <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(`PTG_OFS_COUNT, {16'h0000, sent}, "event count");
    // Each ratio over exactly 2048 clocks between the two samples
    for (int s = 0; s < 8; s++)
    begin
      wr(`PTG_OFS_CTRL, 32'h0000_0000);
      wr(`PTG_OFS_COUNT, 32'h0000_0000);
      wr(`PTG_OFS_CTRL, (s << 4) | 1);
      wb(1'b0, `PTG_OFS_COUNT, 32'h0000_0000);
      q = rdat;
      repeat (2045) @(posedge clk_i);
      wb(1'b0, `PTG_OFS_COUNT, 32'h0000_0000);
      `CHK("ticks", 2048 >> sh[s], rdat - q)
    end
    for (int m = 0; m < 7; m++)
      for (int r = 0; r < 2; r++)
      begin
        rnd = lfsr(rnd);
        wave(m, (m < 3) ? r[0] : 1'b0, 16 + rnd % 32, rnd[11:8]);
      end
    `CHK("irq", 1'b1, irq)
    wr(`PTG_OFS_CTRL, 32'h0000_0000);
    wr(`PTG_OFS_FLAGS, 32'hFFFF_FFFF);
    rchk(`PTG_OFS_FLAGS, 32'h0000_0000, "flags cleared");
    `CHK("irq", 1'b0, irq)
    bufchk(2);
    bufchk(4);
    final_report();
  end
endmodule
